// ---- core/mcapr_arbiter.v ----
`timescale 1ns/1ps
`default_nettype none

// Picks one requesting master: higher priority value wins, lower index on tie
module mcapr_arbiter (
  input wire [3:0] req,    // Request per master
  input wire [11:0] prio,  // Packed 3-bit priority per master
  output reg [3:0] grant   // One-hot grant
);
  integer i;
  reg [2:0] best;
  reg found;

  // Scan from master 0 upward; only a strictly higher value displaces
  always @* begin
    grant = 4'h0;
    best = 3'h0;
    found = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      if (req[i] && (!found || prio[i*3 +: 3] > best)) begin
        grant = 4'h0;
        grant[i] = 1'b1;
        best = prio[i*3 +: 3];
        found = 1'b1;
      end
    end
  end
endmodule // mcapr_arbiter

`default_nettype wire

// ---- core/mcapr_checker.v ----
`timescale 1ns/1ps
`default_nettype none
`include "mcapr_defs.vh"

// Classifies one access as undefined, misaligned or good
module mcapr_checker (
  input wire [31:0] addr,  // Access address
  input wire [1:0] size,   // Access size code
  input wire [1:0] kind,   // Access type code
  input wire is_cpu,       // Access comes from the processor
  output wire undef,       // Undefined internal address
  output wire misal        // Misaligned address
);
  wire fetch_exempt;

  // Internal area above the last memory block has nothing behind it
  assign undef = (addr >= `MCAPR_UNDEF_BASE) && (addr <= `MCAPR_INT_TOP);

  // Processor instruction fetches skip the alignment check
  assign fetch_exempt = is_cpu && (kind == `MCAPR_TYPE_FETCH);
  assign misal = !fetch_exempt &&
    (((size == `MCAPR_SIZE_WORD) && (addr[1:0] != 2'h0)) ||
     ((size == `MCAPR_SIZE_HALF) && addr[0]));
endmodule // mcapr_checker

`default_nettype wire

// ---- core/mcapr_defs.vh ----
`ifndef MCAPR_DEFS_VH
`define MCAPR_DEFS_VH

// Register byte offsets
`define MCAPR_OFS_REMAP 8'h00
`define MCAPR_OFS_ASTAT 8'h04
`define MCAPR_OFS_AADDR 8'h08
`define MCAPR_OFS_PRIO 8'h0C

// Remap control field
`define MCAPR_REMAP_BIT 0

// Abort status field positions
`define MCAPR_UNDEF_BIT 0
`define MCAPR_MISAL_BIT 1
`define MCAPR_SIZE_LO 8
`define MCAPR_TYPE_LO 10
`define MCAPR_SRC_LO 16
`define MCAPR_SAVED_LO 24

// Master priority fields, one 3-bit field every 4 bits
`define MCAPR_PRIO_STRIDE 4
`define MCAPR_PRIO_MASK 32'h00007777
`define MCAPR_PRIO_RESET 32'h00003210

// Access size and type codes
`define MCAPR_SIZE_BYTE 2'h0
`define MCAPR_SIZE_HALF 2'h1
`define MCAPR_SIZE_WORD 2'h2
`define MCAPR_TYPE_READ 2'h0
`define MCAPR_TYPE_WRITE 2'h1
`define MCAPR_TYPE_FETCH 2'h2

// Internal memory map
`define MCAPR_INT_TOP 32'h0FFFFFFF
`define MCAPR_UNDEF_BASE 32'h00400000
`define MCAPR_SRAM_BASE 32'h00200000
`define MCAPR_PAGE0_MASK 32'hFFF00000

`endif

// ---- core/mcapr_top.v ----
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "mcapr_defs.vh"

// Functional notes
// - Writing one to remap bit toggles remap
// - Undefined-address flag marks last abort cause
// - Misaligned flag marks last abort cause
// - Size of last abort in bits 9:8
// - Type of last abort in bits 11:10
// - One-hot last abort source in bits 16-19
// - Saved bits mark earlier untraced aborts
// - Status read clears saved bits
// - Full last abort address at 0x08
// - Three-bit priority per master, higher wins
// - Equal priorities favour lower master index
// - Priority register RW at 0x0C, reset 0x3210
// - Remap shows SRAM at page zero too
// - Misaligned word or half access aborts, except processor fetches
// - Internal access at or above 0x00400000 aborts
module mcapr_top (
  input wire ref_clk,             // System clock, 100 MHz
  input wire arst_n,              // Asynchronous reset, active low
  input wire psel,                // APB select
  input wire penable,             // APB enable
  input wire pwrite,              // APB write
  input wire [7:0] paddr,         // APB byte address
  input wire [31:0] pwdata,       // APB write data
  output reg [31:0] prdata,       // APB read data
  output reg pready,              // APB ready
  output reg pslverr,             // APB error on unmapped offset
  input wire [3:0] mst_req,       // Access request per master
  input wire [127:0] mst_addr,    // Address per master, 32 bits each
  input wire [7:0] mst_size,      // Size code per master, 2 bits each
  input wire [7:0] mst_type,      // Type code per master, 2 bits each
  output reg [3:0] mst_grant,     // One-hot grant of the accepted access
  output reg [3:0] mst_abort,     // One-hot abort to the granted master
  output reg [31:0] mem_addr,     // Address after remap for good access
  output reg mem_valid,           // Good access forwarded to memory
  output reg mem_write,           // Forwarded access is a write
  output reg remap_active         // Page zero shows internal SRAM
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // Software-visible state
  reg remap_q;
  reg undef_q;
  reg misal_q;
  reg [1:0] size_q;
  reg [1:0] type_q;
  reg [3:0] src_q;
  reg [3:0] saved_q;
  reg [3:0] saved_rd_q;
  reg [31:0] aaddr_q;
  reg [11:0] prio_q;

  // Access path
  wire [3:0] gnt;
  wire undef;
  wire misal;
  wire abort;
  reg [31:0] sel_addr;
  reg [1:0] sel_size;
  reg [1:0] sel_type;
  reg [31:0] map_addr;
  reg [31:0] rd_data;
  reg rd_hit;
  reg [3:0] saved_d;
  reg [11:0] prio_d;
  reg remap_d;
  integer k;
  integer m;
  integer n;

  // Bus handshake
  wire apb_setup;
  wire apb_done;
  wire wr_done;
  wire rd_status_setup;
  wire rd_status_done;
  reg [31:0] status_word;
  reg [31:0] prio_word;

  // Priority reset word as software reads it, unpacked on reset
  localparam [31:0] prio_rst_word = `MCAPR_PRIO_RESET;

  // ----------------------------------------------------------------
  // Arbitration between the four masters
  // ----------------------------------------------------------------

  // A losing master is not queued; it keeps its request up and is
  // seen again at the next edge.
  // priority value compare
  mcapr_arbiter u_arb (
    .req(mst_req),
    .prio(prio_q),
    .grant(gnt)
  );

  // Route the granted master's request
  // At most one grant bit is set, so the matching slice is unique
  always @* begin
    sel_addr = 32'h00000000;
    sel_size = 2'h0;
    sel_type = 2'h0;
    for (k = 0; k < 4; k = k + 1) begin
      if (gnt[k]) begin
        sel_addr = mst_addr[k*32 +: 32];
        sel_size = mst_size[k*2 +: 2];
        sel_type = mst_type[k*2 +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Access checking and remap
  // ----------------------------------------------------------------

  // Both causes may be flagged for one access
  // alignment check
  mcapr_checker u_chk (
    .addr(sel_addr),
    .size(sel_size),
    .kind(sel_type),
    .is_cpu(gnt[0]),
    .undef(undef),
    .misal(misal)
  );

  assign abort = (undef || misal) && (gnt != 4'h0);

  // SRAM stays reachable at its own base; only page zero is redirected
  // page zero redirected to SRAM
  always @* begin
    if (remap_q && ((sel_addr & `MCAPR_PAGE0_MASK) == 32'h00000000)) begin
      map_addr = sel_addr | `MCAPR_SRAM_BASE;
    end else begin
      map_addr = sel_addr;
    end
  end

  // Registered grant, abort and forwarded access
  // An aborted access is cancelled, so mem_addr keeps the last good one
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mst_grant <= 4'h0;
      mst_abort <= 4'h0;
      mem_addr <= 32'h00000000;
      mem_valid <= 1'b0;
      mem_write <= 1'b0;
    end else begin
      mst_grant <= gnt;
      mst_abort <= abort ? gnt : 4'h0;
      mem_valid <= (gnt != 4'h0) && !abort;
      mem_write <= (sel_type == `MCAPR_TYPE_WRITE);
      if ((gnt != 4'h0) && !abort) begin
        mem_addr <= map_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // Setup is the first cycle of a transfer, done is the ready edge
  assign apb_setup = psel && !penable;
  assign apb_done = psel && penable && pready;
  assign wr_done = apb_done && pwrite;
  assign rd_status_setup = apb_setup && !pwrite &&
    (paddr == `MCAPR_OFS_ASTAT);
  assign rd_status_done = apb_done && !pwrite &&
    (paddr == `MCAPR_OFS_ASTAT);

  // Status word as software sees it, one field at a time
  always @* begin
    status_word = 32'h00000000;
    status_word[`MCAPR_UNDEF_BIT] = undef_q;
    status_word[`MCAPR_MISAL_BIT] = misal_q;
    status_word[`MCAPR_SIZE_LO +: 2] = size_q;
    status_word[`MCAPR_TYPE_LO +: 2] = type_q;
    status_word[`MCAPR_SRC_LO +: 4] = src_q;
    status_word[`MCAPR_SAVED_LO +: 4] = saved_q;
  end

  // Priority word: a 3-bit field every 4 bits, the gaps read as zero
  always @* begin
    prio_word = 32'h00000000;
    for (m = 0; m < 4; m = m + 1) begin
      prio_word[m*`MCAPR_PRIO_STRIDE +: 3] = prio_q[m*3 +: 3];
    end
  end

  // Read decode; remap register reads as zero
  // Unmapped offsets flag an error and read as zero
  always @* begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    if (paddr == `MCAPR_OFS_REMAP) begin
      rd_data = 32'h00000000;
    end else if (paddr == `MCAPR_OFS_ASTAT) begin
      rd_data = status_word;
    end else if (paddr == `MCAPR_OFS_AADDR) begin
      rd_data = aaddr_q;
    end else if (paddr == `MCAPR_OFS_PRIO) begin
      rd_data = prio_word;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // No wait state: data captured in setup, ready in first access cycle.
  // Read data is taken from the registers at the setup edge, so a
  // change during the access cycle shows up only in the next read.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata <= pwrite ? 32'h00000000 : rd_data;
      pready <= 1'b1;
      pslverr <= !rd_hit;
    end else if (apb_done) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Software-written registers
  // ----------------------------------------------------------------

  // Remap next value: a one in the toggle bit flips, a zero leaves it
  always @* begin
    remap_d = remap_q;
    if (wr_done && (paddr == `MCAPR_OFS_REMAP) &&
        pwdata[`MCAPR_REMAP_BIT]) begin
      remap_d = !remap_q;
    end
  end

  // Priority next value: the 3-bit fields picked out of the write word
  always @* begin
    prio_d = prio_q;
    if (wr_done && (paddr == `MCAPR_OFS_PRIO)) begin
      for (n = 0; n < 4; n = n + 1) begin
        prio_d[n*3 +: 3] = pwdata[n*`MCAPR_PRIO_STRIDE +: 3];
      end
    end
  end

  // Remap state and priority fields; the remap output mirrors the state
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      remap_q <= 1'b0;
      remap_active <= 1'b0;
      prio_q <= {prio_rst_word[14:12], prio_rst_word[10:8],
        prio_rst_word[6:4], prio_rst_word[2:0]};
    end else begin
      remap_q <= remap_d;
      remap_active <= remap_d;
      prio_q <= prio_d;
    end
  end

  // ----------------------------------------------------------------
  // Abort capture
  // ----------------------------------------------------------------

  // Saved sources: read clears only what was shown, new abort sets.
  // A read and an abort in one cycle: the set is applied last, so the
  // newly displaced source is never lost.
  // Saved bits only ever gain a master other than the new source.
  always @* begin
    saved_d = saved_q;
    if (rd_status_done) begin
      saved_d = saved_d & ~saved_rd_q;
    end
    if (abort) begin
      saved_d = saved_d | (src_q & ~gnt);
    end
  end

  // Snapshot of saved bits at the read setup. An abort that lands
  // between setup and completion is not in the returned word, so its
  // saved bit must survive the clear at completion.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      saved_rd_q <= 4'h0;
    end else if (rd_status_setup) begin
      saved_rd_q <= saved_q;
    end
  end

  // Abort description registers
  // Fields other than the saved bits keep their value until the next abort replaces them
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      undef_q <= 1'b0;
      misal_q <= 1'b0;
      size_q <= 2'h0;
      type_q <= 2'h0;
      src_q <= 4'h0;
      saved_q <= 4'h0;
      aaddr_q <= 32'h00000000;
    end else begin
      saved_q <= saved_d;
      if (abort) begin
        undef_q <= undef;
        misal_q <= misal;
        size_q <= sel_size;
        type_q <= sel_type;
        src_q <= gnt;
        aaddr_q <= sel_addr;
      end
    end
  end

endmodule // mcapr_top

`default_nettype wire

// ---- test/mcapr_masters.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behavioural on-chip bus masters facing the arbiter
module mcapr_masters (
  input wire logic ref_clk, // System clock
  output logic [3:0] mst_req, // Request per master
  output logic [127:0] mst_addr, // Address per master
  output logic [7:0] mst_size, // Size per master
  output logic [7:0] mst_type // Type per master
);
  // Idle until a scenario asks
  initial begin
    mst_req = 4'h0;
    mst_addr = 128'h0;
    mst_size = 8'h0;
    mst_type = 8'h0;
  end
  // Load one master's access fields
  task set(input int k, input logic [31:0] a, input logic [1:0] s,
           input logic [1:0] t);
    mst_addr[32*k +: 32] <= a;
    mst_size[2*k +: 2] <= s;
    mst_type[2*k +: 2] <= t;
  endtask
  // Request for one edge only, then scramble the addresses of all masters
  task fire(input logic [3:0] m);
    @(posedge ref_clk);
    mst_req <= m;
    @(posedge ref_clk);
    mst_req <= 4'h0;
    mst_addr <= ~mst_addr;
    #1;
  endtask
endmodule // mcapr_masters
`default_nettype wire

// ---- test/mcapr_top_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcapr_top_sva (
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Write
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic pready, // Ready
  input wire logic [3:0] mst_req, // Requests
  input wire logic [127:0] mst_addr, // Addresses
  input wire logic [7:0] mst_size, // Sizes
  input wire logic [3:0] mst_grant, // Grants
  input wire logic [3:0] mst_abort, // Aborts
  input wire logic mem_valid, // Forwarded
  input wire logic remap_active // Remap state
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Completed remap write with bit 0 set
  wire logic rmp_one = psel && penable && pready && pwrite &&
    paddr == 8'h00 && pwdata[0];
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  remap_toggle_a: assert property (rmp_one |=>
    remap_active != $past(remap_active)) else $error("remap not toggled");
  remap_keep_a: assert property (!rmp_one |=> $stable(remap_active))
    else $error("remap changed");
  remap_reset_a: assert property ($rose(arst_n) |-> !remap_active)
    else $error("remap on after reset");
  grant_onehot_a: assert property (|mst_grant |-> $onehot(mst_grant))
    else $error("grant not one-hot");
  grant_cause_a: assert property (|mst_grant |->
    (mst_grant & $past(mst_req)) == mst_grant) else $error("grant no req");
  abort_granted_a: assert property ((mst_abort & ~mst_grant) == 4'h0)
    else $error("abort without grant");
  abort_excl_a: assert property (mem_valid |-> mst_abort == 4'h0)
    else $error("aborted access forwarded");
  undef_abort_a: assert property (mst_req == 4'h2 &&
    mst_addr[63:32] >= 32'h00400000 && mst_addr[63:32] <= 32'h0FFFFFFF
    |=> mst_abort == 4'h2) else $error("undefined not aborted");
  misal_abort_a: assert property (mst_req == 4'h4 &&
    mst_size[5:4] == 2'h1 && mst_addr[64] |=> mst_abort == 4'h4)
    else $error("misaligned not aborted");
  ready_wait_a: assert property (setup_s ##1 access_s |-> pready)
    else $error("no ready");
endmodule // mcapr_top_sva
bind mcapr_top mcapr_top_sva chk_u (.*);
`default_nettype wire

// ---- test/memory_ctrl_abort_priority_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module memory_ctrl_abort_priority_regs_tb;
  logic ref_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, mem_valid, mem_write;
  logic remap_active, er;
  logic [7:0] paddr = 8'h00, mst_size, mst_type;
  logic [31:0] pwdata = 32'h0, prdata, mem_addr, rd;
  logic [3:0] mst_req, mst_grant, mst_abort;
  logic [127:0] mst_addr;
  int fail_count = 0, samples_checked = 0;
  mcapr_top dut_u (.*);
  mcapr_masters mdl_u (.*);
  // Clock and watchdog
  always #5 ref_clk = ~ref_clk;
  initial begin
    #50000;
    fail_count++;
    print_verdict();
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  // One APB transfer, held until ready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task go(input int k, input logic [31:0] a, input logic [1:0] s,
          input logic [1:0] t, input logic [4:0] e);
    mdl_u.set(k, a, s, t);
    mdl_u.fire(4'h1 << k);
    chk({26'h0, mem_write, mem_valid, mst_abort}, {26'h0, t == 2'h1, e});
  endtask
  task t_reset();
    chk({31'h0, remap_active}, 32'h0);
    rdchk(8'h0C, 32'h00003210);
    rdchk(8'h04, 32'h0);
    rdchk(8'h08, 32'h0);
    rdchk(8'h00, 32'h0);
  endtask
  task t_prio();
    apb(1'b1, 8'h0C, 32'hFFFFFFFF);
    rdchk(8'h0C, 32'h00007777);
    apb(1'b1, 8'h04, 32'hFFFFFFFF);
    rdchk(8'h04, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask
  task t_remap();
    apb(1'b1, 8'h00, 32'hFFFFFFFE);
    chk({31'h0, remap_active}, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    chk({31'h0, remap_active}, 32'h1);
    go(0, 32'h00000010, 2'h2, 2'h0, 5'h10);
    chk(mem_addr, 32'h00200010);
    apb(1'b1, 8'h00, 32'h1);
    go(0, 32'h00000010, 2'h2, 2'h0, 5'h10);
    chk(mem_addr, 32'h00000010);
    go(0, 32'h00000014, 2'h2, 2'h1, 5'h10);
    chk(mem_addr, 32'h00000014);
  endtask
  task t_abort();
    go(1, 32'h00400000, 2'h2, 2'h0, 5'h02);
    rdchk(8'h04, 32'h00020201);
    rdchk(8'h08, 32'h00400000);
    go(2, 32'h00200001, 2'h1, 2'h1, 5'h04);
    rdchk(8'h04, 32'h02040502);
    rdchk(8'h04, 32'h00040502);
    go(3, 32'h00800003, 2'h0, 2'h2, 5'h08);
    rdchk(8'h04, 32'h04080801);
    rdchk(8'h08, 32'h00800003);
    go(0, 32'h00000002, 2'h2, 2'h2, 5'h10);
    go(0, 32'h00000002, 2'h2, 2'h0, 5'h01);
    rdchk(8'h04, 32'h08010202);
  endtask
  task automatic t_arb();
    logic [31:0] pr [5] = '{32'h0, 32'h3210, 32'h7, 32'h70, 32'h444};
    logic [3:0] mk [5] = '{4'hF, 4'hF, 4'hF, 4'h3, 4'hE};
    logic [3:0] gr [5] = '{4'h1, 4'h8, 4'h1, 4'h2, 4'h2};
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 8'h0C, pr[i]);
      for (int k = 0; k < 4; k++) mdl_u.set(k, 32'h00200000, 2'h2, 2'h0);
      mdl_u.fire(mk[i]);
      chk({28'h0, mst_grant}, {28'h0, gr[i]});
    end
  endtask
  task print_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Reset, then scenarios in turn
  initial begin
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset();
    t_prio();
    t_remap();
    t_abort();
    t_arb();
    print_verdict();
  end
endmodule // memory_ctrl_abort_priority_regs_tb
`default_nettype wire
